// [design/bgt_pkg.sv]
// Purpose : Shared constants and types for the boot and general timer
// Assumes : 32-bit register port, 100 MHz clock
// Notes   : Bit 31 of the register word is the auto-reload flag, period in 15:0
package bgt_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [19:0] BGT_CTRL_OFFSET  = 20'h1D35C;   // Timer control register
   localparam int          BGT_RELOAD_BIT   = 31;          // Auto-reload flag position
   localparam int          BGT_PERIOD_LSB   = 0;           // Period field low bit
   localparam logic [15:0] BGT_PERIOD_RESET = 16'h0FA0;    // 4000 ms boot bound
   localparam logic        BGT_RELOAD_RESET = 1'b0;        // Reload off at reset
   localparam logic [31:0] BGT_UNMAPPED     = 32'h00000000; // Read of unmapped offset

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] period;   // Tick count per period
      logic        reload;   // Auto-reload flag
   } bgt_cfg_s;

   typedef enum logic [2:0] {
      BGT_IDLE    = 3'b001,  // Stopped
      BGT_RUN     = 3'b010,  // Counting ticks
      BGT_EXPIRED = 3'b100   // Expiry cycle
   } bgt_state_e;

endpackage : bgt_pkg

// [design/bgt_timer.sv]
// Purpose : Millisecond timer bounding boot load, then general purpose timer
// Assumes : MILLISECOND_TICK is a one-cycle pulse from an external divider
// Notes   : Events are one-cycle registered pulses
`timescale 1ns/1ns

// Functional notes
// - Reload clear: stop after expiry
// - Reload set: restart same period, still signal
// - Period zero disables timer entirely
// - Duration equals period times millisecond tick
// - Register write starts new period
// - Write mid-period restarts, drops old event
// - Boot active: boot timeout, else general event
// - Reset value 0x0FA0, reload cleared
// - Reset value times boot without write
// - Boot done early clears period
module bgt_timer (
   input  wire logic        MCLK,
   input  wire logic        ARST_N,
   input  wire logic        MILLISECOND_TICK,
   input  wire logic        BOOT_ACTIVE,
   input  wire logic [19:0] REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   output logic             GENERAL_TIMER_EVENT,
   output logic             BOOT_LOAD_TIMEOUT_EVENT
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic       rst_meta;   // First release stage
   logic       rst_n;      // Released reset copy

   // Two-stage reset release
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   bgt_pkg::bgt_cfg_s  cfg;          // Programmed period and reload
   bgt_pkg::bgt_state_e state;       // Timer state
   logic [15:0]        ticks;        // Elapsed ticks
   logic               boot_seen;    // Boot was active last cycle

   // Next values
   bgt_pkg::bgt_cfg_s   next_cfg;
   bgt_pkg::bgt_state_e next_state;
   logic [15:0]         next_ticks;
   logic [31:0]         next_rdata;
   logic                next_gen;
   logic                next_boot_to;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [19:0] a);
      hit = (a == bgt_pkg::BGT_CTRL_OFFSET);
   endfunction : hit

   wire wr_hit   = REG_WR & hit(REG_ADDR);                      // Write to timer
   wire rd_hit   = REG_RD & hit(REG_ADDR);                      // Read of timer
   wire boot_end = boot_seen & ~BOOT_ACTIVE;                    // Boot finished
   wire last_tick = MILLISECOND_TICK
                    & (ticks == cfg.period - 16'h0001);
   wire expire   = (state == bgt_pkg::BGT_RUN) & last_tick
                   & (cfg.period != 16'h0000) & ~wr_hit
                   & ~boot_end;
   // Word layout: reload flag on top, period in the low half
   wire [31:0] cfg_word = {cfg.reload, 15'h0000, cfg.period};

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_cfg   = cfg;
      next_state = state;
      next_ticks = ticks;
      // Software write restarts with the new value
      if (wr_hit) begin
         next_cfg.period = REG_WDATA[bgt_pkg::BGT_PERIOD_LSB +: 16];
         next_cfg.reload = REG_WDATA[bgt_pkg::BGT_RELOAD_BIT];
         next_ticks      = 16'h0000;
         next_state      = (REG_WDATA[bgt_pkg::BGT_PERIOD_LSB +: 16] != 16'h0000) ?
                           bgt_pkg::BGT_RUN : bgt_pkg::BGT_IDLE;
      end else if (boot_end && state == bgt_pkg::BGT_RUN) begin
         // Boot done in time: disable the timer
         next_cfg.period = 16'h0000;
         next_state      = bgt_pkg::BGT_IDLE;
      end else begin
         case (state)
            bgt_pkg::BGT_IDLE: begin
               next_ticks = 16'h0000;
            end
            bgt_pkg::BGT_RUN: begin
               if (cfg.period == 16'h0000) begin
                  next_state = bgt_pkg::BGT_IDLE;
               end else if (expire) begin
                  next_ticks = 16'h0000;
                  next_state = cfg.reload ? bgt_pkg::BGT_RUN
                                          : bgt_pkg::BGT_IDLE;
               end else if (MILLISECOND_TICK) begin
                  next_ticks = 16'(ticks + 16'h0001);
               end
            end
            default: begin
               next_state = bgt_pkg::BGT_IDLE;
            end
         endcase
      end
   end

   // Event selection and read data
   always_comb begin
      next_gen     = expire & ~BOOT_ACTIVE;
      next_boot_to = expire & BOOT_ACTIVE;
      next_rdata   = rd_hit ? cfg_word : bgt_pkg::BGT_UNMAPPED;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Timer starts running from reset to bound boot load
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg.period <= bgt_pkg::BGT_PERIOD_RESET;
         cfg.reload <= bgt_pkg::BGT_RELOAD_RESET;
         state      <= bgt_pkg::BGT_RUN;
         ticks      <= 16'h0000;
         boot_seen  <= 1'b0;
         REG_RDATA  <= 32'h00000000;
         GENERAL_TIMER_EVENT     <= 1'b0;
         BOOT_LOAD_TIMEOUT_EVENT <= 1'b0;
      end else begin
         cfg        <= next_cfg;
         state      <= next_state;
         ticks      <= next_ticks;
         boot_seen  <= BOOT_ACTIVE;
         REG_RDATA  <= next_rdata;
         GENERAL_TIMER_EVENT     <= next_gen;
         BOOT_LOAD_TIMEOUT_EVENT <= next_boot_to;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_zero_no_event: assert property (@(posedge MCLK) disable iff (!rst_n)
      (cfg.period == 16'h0000 && !wr_hit) |=> !GENERAL_TIMER_EVENT
      && !BOOT_LOAD_TIMEOUT_EVENT)
      else $error("event with zero period");
   chk_oneshot_stops: assert property (@(posedge MCLK) disable iff (!rst_n)
      (expire && !cfg.reload && !wr_hit) |=> state == bgt_pkg::BGT_IDLE)
      else $error("one-shot timer kept running");
   chk_reload_runs: assert property (@(posedge MCLK) disable iff (!rst_n)
      (expire && cfg.reload) |=> state == bgt_pkg::BGT_RUN
      && ticks == 16'h0000 && (GENERAL_TIMER_EVENT || BOOT_LOAD_TIMEOUT_EVENT))
      else $error("reload failed");
   chk_write_restart: assert property (@(posedge MCLK) disable iff (!rst_n)
      wr_hit |=> ticks == 16'h0000 && cfg.period == $past(REG_WDATA[15:0]))
      else $error("write did not restart");
   chk_write_drops: assert property (@(posedge MCLK) disable iff (!rst_n)
      wr_hit |=> !GENERAL_TIMER_EVENT && !BOOT_LOAD_TIMEOUT_EVENT)
      else $error("event after write");
   chk_event_route: assert property (@(posedge MCLK) disable iff (!rst_n)
      expire |=> (BOOT_LOAD_TIMEOUT_EVENT == $past(BOOT_ACTIVE))
      && (GENERAL_TIMER_EVENT != $past(BOOT_ACTIVE)))
      else $error("event misrouted");
   chk_boot_clear: assert property (@(posedge MCLK) disable iff (!rst_n)
      (boot_end && !wr_hit && state == bgt_pkg::BGT_RUN)
      |=> cfg.period == 16'h0000)
      else $error("period not cleared after boot");
   chk_expire_count: assert property (@(posedge MCLK) disable iff (!rst_n)
      expire |-> MILLISECOND_TICK && ticks == 16'(cfg.period - 16'h0001))
      else $error("expiry at wrong count");
   chk_read_period: assert property (@(posedge MCLK) disable iff (!rst_n)
      rd_hit |=> REG_RDATA == {$past(cfg.reload), 15'h0000, $past(cfg.period)})
      else $error("read returned wrong value");
   chk_reset_value: assert property (@(posedge MCLK)
      $rose(rst_n) |-> cfg.period == bgt_pkg::BGT_PERIOD_RESET
      && !cfg.reload && state == bgt_pkg::BGT_RUN)
      else $error("reset value wrong");

   // ---------------------------------------------------------------
   // Checker helper: independent tick tally
   // ---------------------------------------------------------------
   logic [15:0] ref_ticks;     // Ticks seen since the last start
   logic        ref_restart;   // Period begins afresh next cycle

   // Any start, expiry or boot completion begins a fresh tally
   assign ref_restart = wr_hit | expire | boot_end;

   // Tally kept apart from the timer's own counter
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         ref_ticks <= 16'h0000;                    // Boot bound starts at zero
      end else if (ref_restart) begin
         ref_ticks <= 16'h0000;                    // Fresh period
      end else if (MILLISECOND_TICK && state == bgt_pkg::BGT_RUN) begin
         ref_ticks <= 16'(ref_ticks + 16'h0001);   // One more tick
      end
   end

   // ---------------------------------------------------------------
   // Named sequences for the multi-step checks
   // ---------------------------------------------------------------
   // Write of a non-zero period
   sequence seq_period_write;
      wr_hit && REG_WDATA[15:0] != 16'h0000;
   endsequence : seq_period_write

   // Freshly started period
   sequence seq_fresh_run;
      state == bgt_pkg::BGT_RUN && ticks == 16'h0000;
   endsequence : seq_fresh_run

   // Expiry of the running period
   sequence seq_expiry;
      expire;
   endsequence : seq_expiry

   // One of the two events raised
   sequence seq_event_pulse;
      GENERAL_TIMER_EVENT || BOOT_LOAD_TIMEOUT_EVENT;
   endsequence : seq_event_pulse

   // Boot completion while the timer runs
   sequence seq_boot_done;
      boot_end && !wr_hit && state == bgt_pkg::BGT_RUN;
   endsequence : seq_boot_done

   // Timer stopped with a cleared period
   sequence seq_disabled;
      state == bgt_pkg::BGT_IDLE && cfg.period == 16'h0000;
   endsequence : seq_disabled

   // ---------------------------------------------------------------
   // Further assertions
   // ---------------------------------------------------------------
   // A non-zero write begins counting from zero
   chk_write_starts: assert property (@(posedge MCLK) disable iff (!rst_n)
      seq_period_write |=> seq_fresh_run)
      else $error("write did not start a period");

   // Every expiry shows up as an event
   chk_expiry_signals: assert property (@(posedge MCLK) disable iff (!rst_n)
      seq_expiry |=> seq_event_pulse)
      else $error("expiry without event");

   // Boot completion leaves the timer disabled
   chk_boot_disables: assert property (@(posedge MCLK) disable iff (!rst_n)
      seq_boot_done |=> seq_disabled)
      else $error("boot completion left timer running");

   // Counter matches the independent tally
   chk_tick_mirror: assert property (@(posedge MCLK) disable iff (!rst_n)
      state == bgt_pkg::BGT_RUN |-> ticks == ref_ticks)
      else $error("tick count diverged");

   // Expiry only after period minus one counted ticks
   chk_duration_ticks: assert property (@(posedge MCLK) disable iff (!rst_n)
      expire |-> ref_ticks == 16'(cfg.period - 16'h0001))
      else $error("expiry after wrong duration");

   // Count never reaches the period while running
   chk_ticks_below: assert property (@(posedge MCLK) disable iff (!rst_n)
      state == bgt_pkg::BGT_RUN |-> ticks < cfg.period)
      else $error("count passed period");

   // Writing zero leaves the timer stopped
   chk_zero_write_idle: assert property (@(posedge MCLK) disable iff (!rst_n)
      (wr_hit && REG_WDATA[15:0] == 16'h0000) |=> state == bgt_pkg::BGT_IDLE)
      else $error("zero period started timer");

   // Stopped timer never restarts by itself
   chk_idle_stays: assert property (@(posedge MCLK) disable iff (!rst_n)
      (state == bgt_pkg::BGT_IDLE && !wr_hit) |=> state == bgt_pkg::BGT_IDLE)
      else $error("stopped timer restarted");

   // Stopped timer raises no event
   chk_idle_silent: assert property (@(posedge MCLK) disable iff (!rst_n)
      (state == bgt_pkg::BGT_IDLE && !wr_hit)
      |=> !GENERAL_TIMER_EVENT && !BOOT_LOAD_TIMEOUT_EVENT)
      else $error("event from stopped timer");

   // One-shot expiry stops and keeps the period
   chk_oneshot_idle: assert property (@(posedge MCLK) disable iff (!rst_n)
      (expire && !cfg.reload)
      |=> state == bgt_pkg::BGT_IDLE && cfg.period == $past(cfg.period))
      else $error("one-shot expiry did not stop");

   // Reload expiry starts the next period at once
   chk_reload_fresh: assert property (@(posedge MCLK) disable iff (!rst_n)
      (expire && cfg.reload) |=> seq_fresh_run)
      else $error("reload did not restart");

   // Never both events together
   chk_events_exclusive: assert property (@(posedge MCLK) disable iff (!rst_n)
      !(GENERAL_TIMER_EVENT && BOOT_LOAD_TIMEOUT_EVENT))
      else $error("both events raised");

   // General event only from an expiry outside boot
   chk_gen_source: assert property (@(posedge MCLK) disable iff (!rst_n)
      GENERAL_TIMER_EVENT |-> $past(expire) && !$past(BOOT_ACTIVE))
      else $error("general event without cause");

   // Boot timeout only from an expiry during boot
   chk_boot_source: assert property (@(posedge MCLK) disable iff (!rst_n)
      BOOT_LOAD_TIMEOUT_EVENT |-> $past(expire) && $past(BOOT_ACTIVE))
      else $error("boot timeout without cause");

   // Written reload flag is taken
   chk_reload_write: assert property (@(posedge MCLK) disable iff (!rst_n)
      wr_hit |=> cfg.reload == $past(REG_WDATA[31]))
      else $error("reload flag not taken");

   // Writes elsewhere leave the setup alone
   chk_unmapped_keeps: assert property (@(posedge MCLK) disable iff (!rst_n)
      (REG_WR && !wr_hit && !boot_end) |=> $stable(cfg))
      else $error("unmapped write changed timer");

   // Read data stand only after a read
   chk_rdata_idle: assert property (@(posedge MCLK) disable iff (!rst_n)
      !rd_hit |=> REG_RDATA == 32'h00000000)
      else $error("read data without read");

   // Count holds between ticks
   chk_tick_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
      (state == bgt_pkg::BGT_RUN && !MILLISECOND_TICK && !wr_hit && !boot_end)
      |=> $stable(ticks))
      else $error("count moved without tick");

   // Boot bound runs from reset with no write
   chk_boot_bound_runs: assert property (@(posedge MCLK)
      $rose(rst_n) |-> state == bgt_pkg::BGT_RUN && ticks == 16'h0000)
      else $error("boot bound not running");

endmodule : bgt_timer

// [verification/tb_boot_and_general_timer.sv]
// Purpose : Self-checking bench for the boot and general timer
// Assumes : Ticks come from the bench, two cycles apart
// Notes   : Expected reads and events are queued, a monitor compares
`timescale 1ns/1ns
module tb_boot_and_general_timer;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [19:0] CTRL = bgt_pkg::BGT_CTRL_OFFSET; // Timer register
   logic        mclk, arst_n, tick, boot, wr, rd;  // Clock, reset, inputs
   logic [19:0] addr;                              // Register address
   logic [31:0] wdata, rdata;                      // Register data
   logic        gen_ev, boot_ev;                   // Expiry events
   logic        rd_seen;                           // Read taken last edge
   logic [31:0] rdq[$];                            // Expected read words
   logic [1:0]  evq[$];                            // Expected {boot, general}
   logic [15:0] p;                                 // Random period
   int          bad_count, num_checks;             // Tallies

   bgt_timer u_bgt_timer (.MCLK(mclk), .ARST_N(arst_n), .MILLISECOND_TICK(tick),
      .BOOT_ACTIVE(boot), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdata), .GENERAL_TIMER_EVENT(gen_ev), .BOOT_LOAD_TIMEOUT_EVENT(boot_ev));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic wreg(input logic [19:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [19:0] a, input logic [31:0] e);
      rdq.push_back(e);
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd   <= 1'b0;
   endtask : rreg
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge mclk);
         tick <= 1'b1;
         @(posedge mclk);
         tick <= 1'b0;
      end
   endtask : ticks
   // One full period: no event one tick early, one event after the last
   task automatic period(input int n, input logic [1:0] ev);
      evq.push_back(ev);
      ticks(n - 1);
      cyc(3);
      chk(32'(evq.size()), 32'd1);
      ticks(1);
      cyc(3);
      chk(32'(evq.size()), 32'd0);
   endtask : period
   task automatic results();
      chk(32'(rdq.size() + evq.size()), 32'd0);
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // ------------------------------------------------------------
   // Clock, monitor and watchdog
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Compare read data and events against the oldest notes
   always @(posedge mclk) begin
      if (rd_seen === 1'b1) chk(rdata, rdq.pop_front());
      if ((gen_ev | boot_ev) !== 1'b0)
         chk({boot_ev, gen_ev}, evq.size() ? evq.pop_front() : 2'b00);
      rd_seen <= rd;
   end
   initial begin
      cyc(100000);
      bad_count++;
      results();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {tick, wr, rd, addr, wdata, rd_seen} = '0;
      boot   = 1'b1;
      arst_n = 1'b0;
      void'($urandom(32'hF515));
      cyc(6);
      arst_n <= 1'b1;
      cyc(4);
      rreg(CTRL, 32'h0000_0FA0);
      rreg(CTRL ^ 20'(1 + $urandom % 255), 32'h0000_0000);
      period(16'h0FA0, 2'b10);
      ticks(8);
      boot <= 1'b0;
      p = 16'(2 + $urandom % 8);
      wreg(CTRL, {1'b1, 15'($urandom), p});
      rreg(CTRL, {1'b1, 15'h0000, p});
      repeat (3) period(p, 2'b01);
      wreg(CTRL, 32'h8000_0000);
      ticks(12);
      wreg(CTRL, 32'h0000_0005);
      ticks(3);
      wreg(CTRL, 32'h0000_0004);
      period(4, 2'b01);
      ticks(6);
      boot <= 1'b1;
      wreg(CTRL, 32'h0000_0006);
      ticks(2);
      boot <= 1'b0;
      cyc(3);
      rreg(CTRL, 32'h0000_0000);
      ticks(8);
      cyc(4);
      results();
   end
endmodule : tb_boot_and_general_timer
